/* File: rtl/map_regs_pkg.sv */
// constants, offsets and types shared by the host mapping and error register bank
// Notes on behaviour
// - A quadlet read whose bus offset lies in ffff_f000_0400..ffff_f000_07ff is served from host memory.
// - The host address of such a read is the mapping base (bits 31..10) plus the low ten offset bits.
// - Bits 9..0 of the mapping register cannot be written and always read as zero.
// - The mapping register reads as zero after reset, and software may read and write its base field.
// - A posted write that fails while its data is written has its details recorded in the two error registers.
// - The low error register holds the lower 32 bits of the failed write's destination offset.
// - The high error register holds the requester's bus number in bits 31..22 and node number in 21..16.
// - Bits 15..0 of the high error register hold the upper 16 bits of the failed write's destination offset.
// - Both error registers are read-only to software, written only by hardware, and read as zero from reset until a capture.
// - The organization identifier register always returns a fixed code and ignores writes.
`default_nettype none
package map_regs_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_ROM_MAP = 8'h34;
	localparam logic [7:0] OFS_FAIL_LO = 8'h38;
	localparam logic [7:0] OFS_FAIL_HI = 8'h3c;
	localparam logic [7:0] OFS_ORG_ID = 8'h40;
	localparam logic [7:0] OFS_INT_STATUS = 8'h44;
	localparam logic [7:0] OFS_INT_MASK = 8'h48;
	localparam logic [7:0] OFS_ROM_COUNT = 8'h4c;
	localparam int BASE_LSB = 10;
	localparam int BUSNUM_LSB = 22;
	localparam int NODENUM_LSB = 16;
	localparam logic [31:0] ROM_MAP_RESET = 32'h0000_0000;
	localparam logic [31:0] ROM_MAP_WMASK = 32'hffff_fc00;
	localparam logic [47:0] ROM_WIN_FIRST = 48'hffff_f000_0400;
	localparam logic [47:0] ROM_WIN_LAST = 48'hffff_f000_07ff;
	// arbitrary neutral value, not any real organization code
	localparam logic [31:0] ORG_ID_DEFAULT = 32'h0000_5a5a;
	localparam int NUM_EVENTS = 3;
	localparam int EV_ROM_READ = 0;
	localparam int EV_WRITE_FAIL = 1;
	localparam int EV_FAIL_OVERRUN = 2;
	localparam logic [2:0] EVENTS_RESET = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_REPLY = 3'b100
	} rq_state_t;
endpackage
`default_nettype wire

/* File: rtl/reg_access_if.sv */
// register access strobes between the bus slave and the register bank
`default_nettype none
interface reg_access_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic rd_en;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;
	modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_err, rd_data, rd_err);
	modport bank (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

/* File: rtl/axil_reg_slave.sv */
// axi4-lite slave front end producing single-cycle register strobes
`default_nettype none
module axil_reg_slave
	import map_regs_pkg::*;
(
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, active low
	input wire logic [7:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // byte enables
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic [7:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	reg_access_if.slave ra // strobes to the bank
);
	logic aw_held;
	logic w_held;
	wire aw_take = awvalid & awready;
	wire w_take = wvalid & wready;
	wire ar_take = arvalid & arready;
	assign ra.wr_en = aw_held & w_held & ~bvalid;
	assign ra.rd_en = ar_take;
	assign ra.rd_addr = araddr;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			ra.wr_addr <= 8'h00;
			ra.wr_data <= 32'h0000_0000;
			ra.wr_strb <= 4'h0;
		end else begin
			// ready is low while a word is held, so address and data may arrive in either order
			awready <= ~aw_held & ~aw_take & ~bvalid;
			wready <= ~w_held & ~w_take & ~bvalid;
			if (aw_take) begin
				aw_held <= 1'b1;
				ra.wr_addr <= awaddr;
			end
			if (w_take) begin
				w_held <= 1'b1;
				ra.wr_data <= wdata;
				ra.wr_strb <= wstrb;
			end
			if (ra.wr_en) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= ra.wr_err ? RESP_SLVERR : RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else begin
			arready <= ~rvalid & ~ar_take;
			if (ar_take) begin
				rvalid <= 1'b1;
				rdata <= ra.rd_data;
				rresp <= ra.rd_err ? RESP_SLVERR : RESP_OKAY;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: rtl/rom_redirect.sv */
// decodes the configuration rom window and forms the host memory address
`default_nettype none
module rom_redirect
	import map_regs_pkg::*;
(
	input wire logic [47:0] offset, // bus destination offset
	input wire logic quadlet_read, // request is a quadlet read
	input wire logic [21:0] base, // mapping base field
	output logic hit, // request falls in the rom window
	output logic [31:0] host_addr // redirected host address
);
	wire in_window = (offset >= ROM_WIN_FIRST) && (offset <= ROM_WIN_LAST);
	// block reads are not redirected here; only single quadlets
	assign hit = quadlet_read & in_window;
	assign host_addr = {base, 10'h000} + {22'h00_0000, offset[9:0]};
endmodule
`default_nettype wire

/* File: rtl/link_map_regs.sv */
// host mapping, posted-write error and identifier register bank with rom read redirect
//
// The AXI4-Lite slave port was decided locally.
`default_nettype none
module link_map_regs
	import map_regs_pkg::*;
#(
	parameter logic [31:0] ORG_ID = ORG_ID_DEFAULT
) (
	input wire logic aclk, // 125 mhz clock
	input wire logic aresetn, // sync reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic rq_valid, // incoming read request valid
	output logic rq_ready, // request accepted
	input wire logic [47:0] rq_offset, // request bus offset
	input wire logic rq_quadlet_read, // request is a quadlet read
	output logic hm_req, // host memory read request
	output logic [31:0] hm_addr, // host memory address
	input wire logic hm_ack, // host memory read done
	input wire logic [31:0] hm_rdata, // host memory read data
	output logic rsp_valid, // reply valid
	output logic rsp_hit, // request was served from host memory
	output logic [31:0] rsp_data, // reply quadlet
	input wire logic rsp_ready, // reply taken
	input wire logic pw_fail, // posted write failed, one-cycle pulse
	input wire logic [47:0] pw_fail_offset, // destination offset of the failed write
	input wire logic [9:0] pw_fail_bus, // requester bus number
	input wire logic [5:0] pw_fail_node, // requester node number
	output logic irq // level interrupt
);
	reg_access_if ra();

	axil_reg_slave u_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.ra(ra.slave)
	);

	logic [31:0] rom_image_base_map;
	logic [31:0] failed_write_offset_low;
	logic [31:0] failed_write_source_offset_high;
	logic [NUM_EVENTS-1:0] int_status;
	logic [NUM_EVENTS-1:0] int_mask;
	logic [31:0] rom_read_count;

	// ---- address decode ----
	wire wsel_map = ra.wr_addr == OFS_ROM_MAP;
	wire wsel_lo = ra.wr_addr == OFS_FAIL_LO;
	wire wsel_hi = ra.wr_addr == OFS_FAIL_HI;
	wire wsel_id = ra.wr_addr == OFS_ORG_ID;
	wire wsel_st = ra.wr_addr == OFS_INT_STATUS;
	wire wsel_mask = ra.wr_addr == OFS_INT_MASK;
	wire wsel_cnt = ra.wr_addr == OFS_ROM_COUNT;
	wire wr_mapped = wsel_map | wsel_lo | wsel_hi | wsel_id | wsel_st | wsel_mask | wsel_cnt;
	assign ra.wr_err = ~wr_mapped;

	wire rsel_map = ra.rd_addr == OFS_ROM_MAP;
	wire rsel_lo = ra.rd_addr == OFS_FAIL_LO;
	wire rsel_hi = ra.rd_addr == OFS_FAIL_HI;
	wire rsel_id = ra.rd_addr == OFS_ORG_ID;
	wire rsel_st = ra.rd_addr == OFS_INT_STATUS;
	wire rsel_mask = ra.rd_addr == OFS_INT_MASK;
	wire rsel_cnt = ra.rd_addr == OFS_ROM_COUNT;
	wire rd_mapped = rsel_map | rsel_lo | rsel_hi | rsel_id | rsel_st | rsel_mask | rsel_cnt;
	assign ra.rd_err = ~rd_mapped;

	// ---- byte-lane write mask ----
	logic [31:0] lane_mask;
	genvar gl;
	generate
		for (gl = 0; gl < 4; gl++) begin : g_lane
			assign lane_mask[gl*8 +: 8] = {8{ra.wr_strb[gl]}};
		end
	endgenerate

	wire [31:0] wbits = ra.wr_data & lane_mask;

	// ---- read mux ----
	wire [31:0] st_word = {{(32-NUM_EVENTS){1'b0}}, int_status};
	wire [31:0] mask_word = {{(32-NUM_EVENTS){1'b0}}, int_mask};
	assign ra.rd_data = rsel_map ? (rom_image_base_map & ROM_MAP_WMASK) :
		rsel_lo ? failed_write_offset_low :
		rsel_hi ? failed_write_source_offset_high :
		rsel_id ? ORG_ID :
		rsel_st ? st_word :
		rsel_mask ? mask_word :
		rsel_cnt ? rom_read_count :
		32'h0000_0000;

	// ---- mapping register ----
	// low ten bits never take a write, so the window offset can be or-ed in without carry
	wire [31:0] next_map = (rom_image_base_map & ~(lane_mask & ROM_MAP_WMASK)) |
		(wbits & ROM_MAP_WMASK);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rom_image_base_map <= ROM_MAP_RESET;
		end else if (ra.wr_en && wsel_map) begin
			rom_image_base_map <= next_map;
		end
	end

	wire [21:0] rom_image_base = rom_image_base_map[31:BASE_LSB];

	// ---- redirect decode ----
	logic rq_hit;
	logic [31:0] rq_host_addr;

	rom_redirect u_redirect (
		.offset(rq_offset),
		.quadlet_read(rq_quadlet_read),
		.base(rom_image_base),
		.hit(rq_hit),
		.host_addr(rq_host_addr)
	);

	// ---- request sequencer ----
	rq_state_t state;
	rq_state_t next_state;
	wire rq_take = rq_valid & rq_ready;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (rq_take) begin
					next_state = rq_hit ? ST_FETCH : ST_REPLY;
				end
			end
			ST_FETCH: begin
				if (hm_ack) begin
					next_state = ST_REPLY;
				end
			end
			ST_REPLY: begin
				if (rsp_ready) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ready drops on the accepting edge so a held request is never taken twice
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rq_ready <= 1'b0;
		end else begin
			rq_ready <= (next_state == ST_IDLE) && !rq_take;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hm_req <= 1'b0;
			hm_addr <= 32'h0000_0000;
		end else if (rq_take && rq_hit) begin
			hm_req <= 1'b1;
			hm_addr <= rq_host_addr;
		end else if (hm_ack) begin
			hm_req <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsp_valid <= 1'b0;
			rsp_hit <= 1'b0;
			rsp_data <= 32'h0000_0000;
		end else if (rq_take && !rq_hit) begin
			// requests outside the window are handed back unserved
			rsp_valid <= 1'b1;
			rsp_hit <= 1'b0;
			rsp_data <= 32'h0000_0000;
		end else if (state == ST_FETCH && hm_ack) begin
			rsp_valid <= 1'b1;
			rsp_hit <= 1'b1;
			rsp_data <= hm_rdata;
		end else if (rsp_valid && rsp_ready) begin
			rsp_valid <= 1'b0;
		end
	end

	wire rom_served = (state == ST_FETCH) && hm_ack;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rom_read_count <= 32'h0000_0000;
		end else if (ra.wr_en && wsel_cnt) begin
			rom_read_count <= 32'h0000_0000;
		end else if (rom_served) begin
			rom_read_count <= rom_read_count + 32'h0000_0001;
		end
	end

	// ---- posted-write error capture ----
	// one edge loads both words from the same failure, so the two registers never hold parts of two events
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			failed_write_offset_low <= 32'h0000_0000;
			failed_write_source_offset_high <= 32'h0000_0000;
		end else if (pw_fail) begin
			failed_write_offset_low <= pw_fail_offset[31:0];
			failed_write_source_offset_high[31:BUSNUM_LSB] <= pw_fail_bus;
			failed_write_source_offset_high[BUSNUM_LSB-1:NODENUM_LSB] <= pw_fail_node;
			failed_write_source_offset_high[15:0] <= pw_fail_offset[47:32];
		end
	end

	// ---- interrupt events ----
	logic [NUM_EVENTS-1:0] ev_set;
	assign ev_set[EV_ROM_READ] = rom_served;
	assign ev_set[EV_WRITE_FAIL] = pw_fail;
	// a second failure before software cleared the first overwrites the capture
	assign ev_set[EV_FAIL_OVERRUN] = pw_fail & int_status[EV_WRITE_FAIL];

	wire [NUM_EVENTS-1:0] ev_clr = (ra.wr_en && wsel_st) ? wbits[NUM_EVENTS-1:0] : EVENTS_RESET;
	// a set in the clearing cycle survives
	wire [NUM_EVENTS-1:0] next_status = (int_status & ~ev_clr) | ev_set;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_status <= EVENTS_RESET;
		end else begin
			int_status <= next_status;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_mask <= EVENTS_RESET;
		end else if (ra.wr_en && wsel_mask) begin
			int_mask <= (int_mask & ~lane_mask[NUM_EVENTS-1:0]) | wbits[NUM_EVENTS-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_status & int_mask);
		end
	end
endmodule
`default_nettype wire

/* File: tb/host_mem_model.sv */
// host memory responder for redirected rom reads
`default_nettype none
module host_mem_model (
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, active low
	input wire logic hm_req, // read request
	input wire logic [31:0] hm_addr, // read address
	input wire logic [3:0] delay, // stall cycles before answering
	output logic hm_ack, // one-cycle done pulse
	output logic [31:0] hm_rdata // read data, churns while idle
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] waited;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hm_ack <= 1'b0;
			waited <= 4'h0;
			hm_rdata <= 32'h0;
		end else if (hm_req && !hm_ack && waited >= delay) begin
			hm_ack <= 1'b1;
			hm_rdata <= hm_addr ^ 32'hc3a5_5a3c;
			waited <= 4'h0;
		end else begin
			hm_ack <= 1'b0;
			// stale data must not look valid
			hm_rdata <= ~hm_rdata;
			waited <= (hm_req && !hm_ack) ? waited + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

/* File: tb/link_map_regs_checker.sv */
// port-level assertions for the mapping and error register bank
`default_nettype none
module link_map_regs_checker
	import map_regs_pkg::*;
#(
	parameter logic [31:0] ORG_ID = ORG_ID_DEFAULT
) (
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [1:0] s_axi_rresp, // read response
	input wire logic s_axi_rvalid, // read data valid
	input wire logic rq_valid, // request valid
	input wire logic rq_ready, // request taken
	input wire logic [47:0] rq_offset, // request offset
	input wire logic rq_quadlet_read, // quadlet read
	input wire logic hm_req, // host read request
	input wire logic [31:0] hm_addr, // host address
	input wire logic hm_ack, // host read done
	input wire logic [31:0] hm_rdata, // host data
	input wire logic rsp_valid, // reply valid
	input wire logic rsp_hit, // reply from host memory
	input wire logic [31:0] rsp_data, // reply data
	input wire logic rsp_ready, // reply taken
	input wire logic pw_fail, // failure pulse
	input wire logic [47:0] pw_fail_offset, // failed offset
	input wire logic [9:0] pw_fail_bus, // failed bus number
	input wire logic [5:0] pw_fail_node // failed node number
);
	wire rq_take;
	wire in_win;
	wire rd_take;
	wire [9:0] low_ofs;
	logic seen;
	logic [31:0] cap_lo;
	logic [31:0] cap_hi;
	assign rq_take = rq_valid && rq_ready;
	assign in_win = rq_quadlet_read && rq_offset >= ROM_WIN_FIRST && rq_offset <= ROM_WIN_LAST;
	assign rd_take = s_axi_arvalid && s_axi_arready;
	assign low_ofs = rq_offset[9:0];
	// captures are undefined until the first failure, so only compare after one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seen <= 1'b0;
		end else if (pw_fail) begin
			seen <= 1'b1;
		end
	end
	always_ff @(posedge aclk) begin
		if (pw_fail) begin
			cap_lo <= pw_fail_offset[31:0];
			cap_hi <= {pw_fail_bus, pw_fail_node, pw_fail_offset[47:32]};
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_hit_fetch: assert property (rq_take && in_win |=>
		hm_req && !rsp_valid && hm_addr[9:0] == $past(low_ofs))
		else $error("window read did not start a host fetch");
	a_miss_reply: assert property (rq_take && !in_win |=> rsp_valid && !rsp_hit && rsp_data == 32'h0 && !hm_req)
		else $error("read outside window was redirected");
	a_fetch_reply: assert property (hm_req && hm_ack |=> rsp_valid && rsp_hit && rsp_data == $past(hm_rdata))
		else $error("fetched quadlet not returned");
	a_reply_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_hit))
		else $error("reply changed before taken");
	a_fetch_wait: assert property (hm_req && !hm_ack |=> hm_req && $stable(hm_addr))
		else $error("host fetch dropped early");
	a_map_low_zero: assert property (rd_take && s_axi_araddr == OFS_ROM_MAP |=> s_axi_rdata[9:0] == 10'h0)
		else $error("mapping low bits not zero");
	a_org_fixed: assert property (rd_take && s_axi_araddr == OFS_ORG_ID |=>
		s_axi_rvalid && s_axi_rdata == ORG_ID && s_axi_rresp == RESP_OKAY)
		else $error("identifier read wrong");
	a_fail_low: assert property (rd_take && s_axi_araddr == OFS_FAIL_LO && seen && !pw_fail |=>
		s_axi_rdata == cap_lo)
		else $error("low failure capture wrong");
	a_fail_high: assert property (rd_take && s_axi_araddr == OFS_FAIL_HI && seen && !pw_fail |=>
		s_axi_rdata == cap_hi)
		else $error("high failure capture wrong");
endmodule
bind link_map_regs link_map_regs_checker #(.ORG_ID(ORG_ID)) u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .rq_valid(rq_valid),
	.rq_ready(rq_ready), .rq_offset(rq_offset), .rq_quadlet_read(rq_quadlet_read), .hm_req(hm_req),
	.hm_addr(hm_addr), .hm_ack(hm_ack), .hm_rdata(hm_rdata), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit),
	.rsp_data(rsp_data), .rsp_ready(rsp_ready), .pw_fail(pw_fail), .pw_fail_offset(pw_fail_offset),
	.pw_fail_bus(pw_fail_bus), .pw_fail_node(pw_fail_node));
`default_nettype wire

/* File: tb/link_map_regs_tb.sv */
// self-checking bench for the mapping, error and identifier register bank
`default_nettype none
module link_map_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import map_regs_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h0;
	logic [7:0] araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic rq_valid = 1'b0;
	logic rq_quad = 1'b0;
	logic rsp_ready = 1'b0;
	logic pw_fail = 1'b0;
	logic [47:0] rq_offset = 48'h0;
	logic [47:0] pf_off = 48'h0;
	logic [9:0] pf_bus = 10'h0;
	logic [5:0] pf_node = 6'h0;
	logic [3:0] delay = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, rq_ready, hm_req, hm_ack, rsp_valid, rsp_hit, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, hm_addr, hm_rdata, rsp_data, base;
	logic [1:0] exp_b[$];
	logic [33:0] exp_r[$];
	logic [32:0] exp_q[$];
	integer seed = 15394;
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;
	int hits = 0;
	always #4 aclk = ~aclk;
	link_map_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rq_valid(rq_valid),
		.rq_ready(rq_ready), .rq_offset(rq_offset), .rq_quadlet_read(rq_quad), .hm_req(hm_req),
		.hm_addr(hm_addr), .hm_ack(hm_ack), .hm_rdata(hm_rdata), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit),
		.rsp_data(rsp_data), .rsp_ready(rsp_ready), .pw_fail(pw_fail), .pw_fail_offset(pf_off),
		.pw_fail_bus(pf_bus), .pw_fail_node(pf_node), .irq(irq));
	host_mem_model mem (.aclk(aclk), .aresetn(aresetn), .hm_req(hm_req), .hm_addr(hm_addr), .delay(delay),
		.hm_ack(hm_ack), .hm_rdata(hm_rdata));
	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] want);
		checks_done++;
		if (seen !== want) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic wrap_up();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// results are compared where they appear, against notes queued by the drivers
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles > 20000) begin
			n_mismatch++;
			wrap_up();
		end
		if (bvalid && bready) check("bresp", bresp, exp_b.pop_front());
		if (rvalid && rready) check("rdata", {rresp, rdata}, exp_r.pop_front());
		if (rsp_valid && rsp_ready) check("reply", {rsp_hit, rsp_data}, exp_q.pop_front());
		// random stalls on the reply side exercise the hold behaviour
		rsp_ready <= ($random(seed) & 1) != 0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		exp_b.push_back(r);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_r.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
		// one idle edge, so a following read never raises rready in the step that lowered it
		@(posedge aclk);
	endtask
	task automatic rq(input logic [47:0] o, input logic q);
		logic hit;
		hit = q && o >= ROM_WIN_FIRST && o <= ROM_WIN_LAST;
		exp_q.push_back(hit ? {1'b1, {base[31:10], o[9:0]} ^ 32'hc3a5_5a3c} : 33'h0);
		hits += hit;
		delay <= 4'($unsigned($random(seed)) % 6);
		rq_offset <= o;
		rq_quad <= q;
		rq_valid <= 1'b1;
		do @(posedge aclk); while (!rq_ready);
		rq_valid <= 1'b0;
		rq_offset <= ~o;
		do @(posedge aclk); while (!rq_ready);
	endtask
	task automatic fail(input logic [31:0] status);
		logic [47:0] o;
		logic [15:0] id;
		o = {16'($random(seed)), 32'($random(seed))};
		id = 16'($random(seed));
		pf_off <= o;
		pf_bus <= id[15:6];
		pf_node <= id[5:0];
		pw_fail <= 1'b1;
		@(posedge aclk);
		pw_fail <= 1'b0;
		pf_off <= ~o;
		rd(OFS_FAIL_LO, {RESP_OKAY, o[31:0]});
		wr(OFS_FAIL_HI, 32'h0, RESP_OKAY);
		rd(OFS_FAIL_HI, {RESP_OKAY, id, o[47:32]});
		rd(OFS_INT_STATUS, {RESP_OKAY, status});
		check("irq", irq, 1'b1);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		base = 32'h0;
		rd(OFS_ROM_MAP, {RESP_OKAY, ROM_MAP_RESET});
		rd(OFS_ORG_ID, {RESP_OKAY, ORG_ID_DEFAULT});
		wr(OFS_ROM_MAP, 32'hffff_ffff, RESP_OKAY);
		rd(OFS_ROM_MAP, {RESP_OKAY, ROM_MAP_WMASK});
		wr(OFS_ORG_ID, 32'h0, RESP_OKAY);
		wr(8'h80, 32'h1, RESP_SLVERR);
		rd(8'h80, {RESP_SLVERR, 32'h0});
		rd(OFS_ORG_ID, {RESP_OKAY, ORG_ID_DEFAULT});
		base = $random(seed);
		wr(OFS_ROM_MAP, base, RESP_OKAY);
		rd(OFS_ROM_MAP, {RESP_OKAY, base & ROM_MAP_WMASK});
		rq(ROM_WIN_FIRST, 1'b1);
		rq(ROM_WIN_LAST, 1'b1);
		rq(ROM_WIN_FIRST - 48'h1, 1'b1);
		rq(ROM_WIN_LAST + 48'h1, 1'b1);
		rq(ROM_WIN_FIRST, 1'b0);
		for (int i = 0; i < 12; i++) begin
			if (i % 3 == 2) begin
				rq({16'($random(seed)), 32'($random(seed))}, 1'b1);
			end else begin
				rq({ROM_WIN_FIRST[47:10], 10'($random(seed))}, ($random(seed) & 1) != 0);
			end
		end
		rd(OFS_ROM_COUNT, {RESP_OKAY, 32'(hits)});
		// any write to the served-read count clears it
		wr(OFS_ROM_COUNT, 32'hffff_ffff, RESP_OKAY);
		rd(OFS_ROM_COUNT, {RESP_OKAY, 32'h0000_0000});
		check("irq", irq, 1'b0);
		wr(OFS_INT_MASK, 32'h7, RESP_OKAY);
		check("irq", irq, 1'b1);
		wr(OFS_INT_STATUS, 32'h7, RESP_OKAY);
		check("irq", irq, 1'b0);
		fail(32'h2);
		fail(32'h6);
		wr(OFS_INT_MASK, 32'h0, RESP_OKAY);
		check("irq", irq, 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
